// file: hdl/ogs_pkg.sv
package ogs_pkg;

  // ****************************************************************
  // Register map (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [11:0] OFS_LO_ADDR = 12'h000;
  localparam logic [11:0] OFS_MID_ADDR = 12'h004;
  localparam logic [11:0] OFS_HI_ADDR = 12'h008;
  localparam logic [11:0] GAIN_LO_ADDR = 12'h00C;
  localparam logic [11:0] GAIN_MID_ADDR = 12'h010;
  localparam logic [11:0] GAIN_HI_ADDR = 12'h014;
  localparam logic [11:0] PGA_ADDR = 12'h018;
  localparam logic [11:0] STATUS_ADDR = 12'h01C;
  localparam logic [11:0] LAST_ADDR = 12'h020;

  // ****************************************************************
  // Field widths and values
  // ****************************************************************
  localparam int DATA_W = 24;
  localparam int PGA_W = 3;
  localparam logic [23:0] OFS_RESET = 24'h000000;
  localparam logic [23:0] GAIN_UNITY = 24'h400000;
  localparam int GAIN_SHIFT = 22;
  localparam logic [23:0] CODE_MAX = 24'h7FFFFF;
  localparam logic [23:0] CODE_MIN = 24'h800000;
  localparam logic [2:0] PGA_RESET = 3'h0;

  // Sample carried between filter, scaler and output path
  typedef struct packed {
    logic valid;
    logic [23:0] code;
  } ogs_sample_t;

  // Calibration update from the calibration sequencer
  typedef struct packed {
    logic ofs_load;
    logic gain_load;
    logic [23:0] value;
  } ogs_cal_t;

endpackage : ogs_pkg

// file: hdl/ogs_scale.sv
`timescale 1ns/1ps
// One-cycle scaling pipeline: subtract, multiply, clip
module ogs_scale #(
  parameter int W = 24
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire ogs_pkg::ogs_sample_t in_smp,
  input wire logic [W-1:0] offset_word,
  input wire logic [W-1:0] gain_word,
  output ogs_pkg::ogs_sample_t out_smp
);

  ogs_pkg::ogs_sample_t out_q;
  ogs_pkg::ogs_sample_t out_d;
  logic signed [W:0] diff;
  logic signed [2*W+1:0] prod;
  logic signed [2*W+1:0] scaled;

  // ****************************************************************
  // Datapath
  // ****************************************************************
  // Extra sign bit keeps the difference exact over full range
  always_comb begin
    diff = $signed({in_smp.code[W-1], in_smp.code}) - $signed({offset_word[W-1], offset_word});
    prod = (2*W+2)'(diff) * $signed({2'b00, gain_word});
    scaled = prod >>> ogs_pkg::GAIN_SHIFT;
    out_d.valid = in_smp.valid;
    // Saturate instead of wrapping
    if (scaled > $signed((2*W+2)'(ogs_pkg::CODE_MAX))) begin
      out_d.code = ogs_pkg::CODE_MAX;
    end else if (scaled < -$signed((2*W+2)'(ogs_pkg::CODE_MIN))) begin
      out_d.code = ogs_pkg::CODE_MIN;
    end else begin
      out_d.code = scaled[W-1:0];
    end
  end

  // Result register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign out_smp = out_q;

endmodule : ogs_scale

// file: hdl/ogs_top.sv
`timescale 1ns/1ps
// What this block does
// - Each result is the filter output minus the offset word, times the gain word over 400000h.
// - The scaled result is clipped to 24 bits, never wrapped.
// - The offset word is one 24-bit value built from three 8-bit registers.
// - The offset word is signed two's complement from 7FFFFFh down to 800000h.
// - An offset word of zero with the gain word at 400000h leaves the filter output unchanged.
// - Both correction words load from register writes or from calibration updates.
// - Offsets over the full negative to positive range are allowed, overflow is clipped.
// - The gain word is unsigned, with 400000h meaning unity.
// - A change of amplifier gain setting reloads the gain word with its trimmed default.
module ogs_top #(
  parameter int W = 24,
  parameter logic [23:0] TRIM_G0 = 24'h400000,
  parameter logic [23:0] TRIM_G1 = 24'h400000,
  parameter logic [23:0] TRIM_G2 = 24'h400000,
  parameter logic [23:0] TRIM_G3 = 24'h400000,
  parameter logic [23:0] TRIM_G4 = 24'h400000,
  parameter logic [23:0] TRIM_G5 = 24'h400000,
  parameter logic [23:0] TRIM_G6 = 24'h400000,
  parameter logic [23:0] TRIM_G7 = 24'h400000
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ogs_pkg::ogs_sample_t filt_smp,
  input wire ogs_pkg::ogs_cal_t cal_upd,
  output ogs_pkg::ogs_sample_t out_smp
);

  logic [23:0] offset_correction_word_q;
  logic [23:0] offset_correction_word_d;
  logic [23:0] gain_correction_word_q;
  logic [23:0] gain_correction_word_d;
  logic [2:0] pga_q;
  logic [2:0] pga_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [23:0] last_code_q;
  logic [23:0] last_code_d;
  logic [23:0] trim_val;
  logic wr_en;
  logic rd_en;
  logic acc;
  logic mapped;
  logic setup;
  logic [31:0] rd_word;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Map, payload in the low bits of each aligned word, one byte except 3 bits at 18h and the 24-bit code at 1Ch:
  //   00h, 04h, 08h  offset word, low, middle and high byte
  //   0Ch, 10h, 14h  gain word, low, middle and high byte
  //   18h            amplifier gain setting, bits 2:0
  //   1Ch            last delivered code, read only
  // Anything else, or a misaligned address, is refused with pslverr.

  // Zero-wait slave: the access phase completes in its first cycle.
  // Read data and the error flag are captured at the end of the setup
  // cycle, so they come from flip-flops yet already stand while pready
  // is high. The cost: a read shows the register as it was at the setup
  // edge, one cycle before the access edge.
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign wr_en = acc && pwrite;
  assign rd_en = setup && !pwrite;
  // LAST_ADDR is the first offset past the map, so it is refused too
  assign mapped = (paddr[1:0] == 2'h0) && (paddr < ogs_pkg::LAST_ADDR);
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // ****************************************************************
  // Correction words
  // ****************************************************************
  // Factory trim per gain setting, looked up from the setting being
  // written so the reload does not feed back through pga_d
  always_comb begin
    case (pwdata[2:0])
      3'h0: trim_val = TRIM_G0;
      3'h1: trim_val = TRIM_G1;
      3'h2: trim_val = TRIM_G2;
      3'h3: trim_val = TRIM_G3;
      3'h4: trim_val = TRIM_G4;
      3'h5: trim_val = TRIM_G5;
      3'h6: trim_val = TRIM_G6;
      3'h7: trim_val = TRIM_G7;
      default: trim_val = ogs_pkg::GAIN_UNITY;
    endcase
  end

  // Bus writes first, then calibration loads override; trim reload wins
  // last because a new gain setting invalidates any older gain word
  always_comb begin
    offset_correction_word_d = offset_correction_word_q;
    gain_correction_word_d = gain_correction_word_q;
    pga_d = pga_q;
    if (wr_en && mapped) begin
      case (paddr)
        ogs_pkg::OFS_LO_ADDR: offset_correction_word_d[7:0] = pwdata[7:0];
        ogs_pkg::OFS_MID_ADDR: offset_correction_word_d[15:8] = pwdata[7:0];
        ogs_pkg::OFS_HI_ADDR: offset_correction_word_d[23:16] = pwdata[7:0];
        ogs_pkg::GAIN_LO_ADDR: gain_correction_word_d[7:0] = pwdata[7:0];
        ogs_pkg::GAIN_MID_ADDR: gain_correction_word_d[15:8] = pwdata[7:0];
        ogs_pkg::GAIN_HI_ADDR: gain_correction_word_d[23:16] = pwdata[7:0];
        ogs_pkg::PGA_ADDR: pga_d = pwdata[2:0];
        default: ;
      endcase
    end
    // Calibration results, one-cycle load pulses
    if (cal_upd.ofs_load) begin
      offset_correction_word_d = cal_upd.value;
    end
    if (cal_upd.gain_load) begin
      gain_correction_word_d = cal_upd.value;
    end
    // Rewriting the same setting keeps the gain word
    if (pga_d != pga_q) begin
      gain_correction_word_d = trim_val;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Register selected by the address of the setup cycle;
  // unused upper bits and unmapped offsets read zero
  always_comb begin
    rd_word = 32'h00000000;
    if (mapped) begin
      case (paddr)
        ogs_pkg::OFS_LO_ADDR: rd_word = {24'h000000, offset_correction_word_q[7:0]};
        ogs_pkg::OFS_MID_ADDR: rd_word = {24'h000000, offset_correction_word_q[15:8]};
        ogs_pkg::OFS_HI_ADDR: rd_word = {24'h000000, offset_correction_word_q[23:16]};
        ogs_pkg::GAIN_LO_ADDR: rd_word = {24'h000000, gain_correction_word_q[7:0]};
        ogs_pkg::GAIN_MID_ADDR: rd_word = {24'h000000, gain_correction_word_q[15:8]};
        ogs_pkg::GAIN_HI_ADDR: rd_word = {24'h000000, gain_correction_word_q[23:16]};
        ogs_pkg::PGA_ADDR: rd_word = {29'h0000000, pga_q};
        ogs_pkg::STATUS_ADDR: rd_word = {8'h00, last_code_q};
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  // Last delivered code, kept for the status read
  always_comb begin
    last_code_d = out_smp.valid ? out_smp.code : last_code_q;
  end

  // Answer latched in the setup cycle and held until the next one;
  // the error flag drops again at the access edge
  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (setup) begin
      pslverr_d = !mapped;
      prdata_d = 32'h00000000;
    end
    if (rd_en && mapped) begin
      prdata_d = rd_word;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Correction words and gain setting;
  // the gain word starts at the trim of setting 0
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      offset_correction_word_q <= ogs_pkg::OFS_RESET;
      gain_correction_word_q <= TRIM_G0;
      pga_q <= ogs_pkg::PGA_RESET;
    end else begin
      offset_correction_word_q <= offset_correction_word_d;
      gain_correction_word_q <= gain_correction_word_d;
      pga_q <= pga_d;
    end
  end

  // Bus answer and status capture
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
      last_code_q <= 24'h000000;
    end else begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      last_code_q <= last_code_d;
    end
  end

  // ****************************************************************
  // Scaling datapath
  // ****************************************************************
  // One cycle of latency. The words in use are those registered at the
  // sample's edge, so a word written in the same cycle as a sample only
  // applies from the next sample on.
  ogs_scale #(
    .W(W)
  ) u_scale (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_smp(filt_smp),
    .offset_word(offset_correction_word_q),
    .gain_word(gain_correction_word_q),
    .out_smp(out_smp)
  );

endmodule : ogs_top

// file: test/ogs_checker.sv
`timescale 1ns/1ps
module ogs_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ogs_pkg::ogs_sample_t filt_smp,
  input wire ogs_pkg::ogs_sample_t out_smp
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ****************************************
  // Access phases, refused and accepted
  // ****************************************
  sequence s_bad;
    psel && penable && (paddr >= ogs_pkg::LAST_ADDR || paddr[1:0] != 2'h0);
  endsequence
  sequence s_good;
    psel && penable && paddr < ogs_pkg::LAST_ADDR && paddr[1:0] == 2'h0;
  endsequence
  // Bus answers and sample latency
  a_pready_high: assert property (pready) else $error("pready low");
  a_out_latency: assert property (filt_smp.valid |=> out_smp.valid) else $error("no result");
  a_no_spurious: assert property (!filt_smp.valid |=> !out_smp.valid) else $error("extra result");
  // Answer is latched at the setup edge, so it stands in the access cycle
  a_slverr_bad: assert property (s_bad |-> pslverr) else $error("no slverr");
  a_slverr_good: assert property (s_good |-> !pslverr) else $error("bad slverr");
  a_idle_no_err: assert property (!(psel && penable) |-> !pslverr) else $error("slverr idle");
  a_unmapped_rd0: assert property (s_bad ##0 !pwrite |-> prdata == 32'h0) else $error("rd nonzero");
  a_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
endmodule : ogs_checker
bind ogs_top ogs_checker u_chk (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .filt_smp(filt_smp), .out_smp(out_smp));

// file: test/ogs_filt_model.sv
`timescale 1ns/1ps
module ogs_filt_model (
  input wire logic core_clk,
  input wire logic req,
  input wire logic [23:0] code,
  output ogs_pkg::ogs_sample_t filt_smp
);
  initial filt_smp = '0;
  // Idle code is inverted each cycle so a stale word never passes
  always @(posedge core_clk) begin
    filt_smp.valid <= req;
    filt_smp.code <= req ? code : ~filt_smp.code;
  end
endmodule : ogs_filt_model

// file: test/ogs_top_tb.sv
`timescale 1ns/1ps
module ogs_top_tb;
  typedef struct packed {logic [23:0] x, o, g;} ogs_vec_t;
  logic core_clk = 1'h0, resetn, psel, penable, pwrite, pready, pslverr, req, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [23:0] code;
  ogs_pkg::ogs_sample_t filt_smp, out_smp;
  ogs_pkg::ogs_cal_t cal_upd;
  int error_cnt, n_checks;
  ogs_vec_t tbl [10] = '{'{24'h123456, 24'h000000, 24'h400000}, '{24'h000000, 24'h7FFFFF, 24'h400000},
    '{24'h000000, 24'h800000, 24'h400000}, '{24'h000000, 24'hFFFFFF, 24'h400000},
    '{24'h300000, 24'h000000, 24'h800000}, '{24'hB00000, 24'h000000, 24'h800000},
    '{24'h000003, 24'h000000, 24'h200000}, '{24'hFFFFFD, 24'h000000, 24'h200000},
    '{24'h800000, 24'h7FFFFF, 24'h400000}, '{24'h654321, 24'h000000, 24'h000000}};
  always #5 core_clk = ~core_clk;
  ogs_top #(.TRIM_G1(24'h200000)) uut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .filt_smp(filt_smp), .cal_upd(cal_upd), .out_smp(out_smp));
  ogs_filt_model u_filt (.core_clk(core_clk), .req(req), .code(code), .filt_smp(filt_smp));
  // ****************************************
  // Verdict, compare and bus tasks
  // ****************************************
  task summarize;
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  // Read data and error are taken at the edge where pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'h1 && i < 16);
    if (pready !== 1'h1) begin
      error_cnt++;
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask : apb
  task wr24(input logic [11:0] a, input logic [23:0] v);
    for (int k = 0; k < 3; k++) apb(1'h1, a + 12'(4 * k), {24'h0, v[8 * k +: 8]});
  endtask : wr24
  task chk24(input logic [11:0] a, input logic [23:0] v);
    for (int k = 0; k < 3; k++) begin
      apb(1'h0, a + 12'(4 * k), 32'h0);
      chk({24'h0, r[7:0]}, {24'h0, v[8 * k +: 8]});
    end
  endtask : chk24
  task smp(input logic [23:0] x, input logic [23:0] y);
    int i;
    req <= 1'h1;
    code <= x;
    @(posedge core_clk);
    req <= 1'h0;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (out_smp.valid !== 1'h1 && i < 8);
    if (out_smp.valid !== 1'h1) begin
      error_cnt++;
      summarize();
    end
    chk({8'h0, out_smp.code}, {8'h0, y});
  endtask : smp
  // Reference scaling; floor shift, then clip to 24 bits
  function automatic logic [23:0] f_ref(input logic [23:0] x, input logic [23:0] o, input logic [23:0] g);
    logic signed [49:0] p;
    p = ($signed({x[23], x}) - $signed({o[23], o})) * $signed({1'h0, g});
    p = p >>> ogs_pkg::GAIN_SHIFT;
    if (p > 50'sh7FFFFF) return ogs_pkg::CODE_MAX;
    if (p < -50'sh800000) return ogs_pkg::CODE_MIN;
    return p[23:0];
  endfunction : f_ref
  // Main sequence
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, req, code, cal_upd} <= '0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    chk24(ogs_pkg::OFS_LO_ADDR, ogs_pkg::OFS_RESET);
    chk24(ogs_pkg::GAIN_LO_ADDR, ogs_pkg::GAIN_UNITY);
    for (int k = 0; k < 2; k++) begin
      apb(1'h1, k ? 12'h002 : ogs_pkg::LAST_ADDR, 32'hFF);
      chk({31'h0, e}, 32'h1);
      apb(1'h0, k ? 12'h002 : ogs_pkg::LAST_ADDR, 32'h0);
      chk(r, 32'h0);
    end
    chk24(ogs_pkg::OFS_LO_ADDR, ogs_pkg::OFS_RESET);
    foreach (tbl[k]) begin
      wr24(ogs_pkg::OFS_LO_ADDR, tbl[k].o);
      wr24(ogs_pkg::GAIN_LO_ADDR, tbl[k].g);
      smp(tbl[k].x, f_ref(tbl[k].x, tbl[k].o, tbl[k].g));
    end
    apb(1'h0, ogs_pkg::STATUS_ADDR, 32'h0);
    chk({8'h0, r[23:0]}, 32'h0);
    // Calibration pulses reach both words
    cal_upd <= {1'h1, 1'h0, 24'h000010};
    @(posedge core_clk);
    cal_upd <= {1'h0, 1'h1, 24'h200000};
    @(posedge core_clk);
    cal_upd <= '0;
    smp(24'h000100, 24'h000078);
    chk24(ogs_pkg::OFS_LO_ADDR, 24'h000010);
    // A new gain setting reloads trim, an unchanged one does not
    wr24(ogs_pkg::GAIN_LO_ADDR, 24'h123456);
    apb(1'h1, ogs_pkg::PGA_ADDR, 32'h1);
    chk24(ogs_pkg::GAIN_LO_ADDR, 24'h200000);
    wr24(ogs_pkg::GAIN_LO_ADDR, 24'h400000);
    apb(1'h1, ogs_pkg::PGA_ADDR, 32'h1);
    chk24(ogs_pkg::GAIN_LO_ADDR, 24'h400000);
    summarize();
  end
endmodule : ogs_top_tb
